// >>> src/csc_pkg.sv
// constants shared by the charger supervisor control block
package csc_pkg;
  // register map, power manager bus byte offset
  localparam logic [7:0] BUCK_CTRL_ADDR = 8'h3e;
  localparam logic [7:0] BUCK_CTRL_RST  = 8'h80;
  // field positions of charger_buck_control
  localparam int BUCK_ILIM_LSB = 0;
  localparam int BUCK_ILIM_MSB = 3;
  localparam int BUCK_EN_BIT   = 4;
  localparam int BUCK_LP_BIT   = 5;
  localparam int USB_AUTO_BIT  = 6;
  localparam int THERM_EN_BIT  = 7;
  // backup charger code ranges
  localparam logic [4:0] BKP_VOLT_MAX_CODE = 5'h14;
  // timing
  localparam int CLK_MHZ           = 10;
  localparam int CUR_STEP_US       = 1000;
  localparam int TIMER_TICK_MS     = 1000;
  localparam int CUR_STEP_CYCLES   = CUR_STEP_US * CLK_MHZ;
  localparam int TIMER_TICK_CYCLES = TIMER_TICK_MS * 1000 * CLK_MHZ;
  // pin synchroniser width
  localparam int NUM_PINS = 13;
  // battery switch positions
  typedef enum logic [1:0] {
    SW_OPEN,
    SW_RAIL,
    SW_BACKUP
  } csc_sw_state_t;
endpackage : csc_pkg

// >>> src/csc_sync.sv
// two-stage synchroniser for a group of pin levels
`timescale 1ns/1ns
module csc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_resetn,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      meta   <= '0;
      o_sync <= '0;
    end else begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end
endmodule : csc_sync

// >>> src/csc_tick.sv
// free running divider giving one pulse every CYCLES clocks
`timescale 1ns/1ns
module csc_tick #(
  parameter int CYCLES = 10
) (
  input  wire logic i_clk,
  input  wire logic i_resetn,
  input  wire logic i_clear,
  output logic      o_tick
);
  localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  logic [CW-1:0] cnt;

  // clear restarts the interval so the first tick is a full period away
  always_ff @(posedge i_clk) begin
    if (!i_resetn || i_clear) begin
      cnt    <= '0;
      o_tick <= 1'b0;
    end else if (cnt == CW'(CYCLES - 1)) begin
      cnt    <= '0;
      o_tick <= 1'b1;
    end else begin
      cnt    <= cnt + 1'b1;
      o_tick <= 1'b0;
    end
  end
endmodule : csc_tick

// >>> src/csc_top.sv
// charger supervisor: charge current control, active diode, safety timer, backup charger, battery switch
`timescale 1ns/1ns
module csc_top #(
  parameter int CUR_STEP_CYCLES   = csc_pkg::CUR_STEP_CYCLES,
  parameter int TIMER_TICK_CYCLES = csc_pkg::TIMER_TICK_CYCLES,
  parameter int TIMER_W           = 8
) (
  input  wire logic               i_clk,
  input  wire logic               i_resetn,
  // register access from the power manager bus
  input  wire logic               i_reg_wr,
  input  wire logic               i_reg_rd,
  input  wire logic [7:0]         i_reg_addr,
  input  wire logic [7:0]         i_reg_wdata,
  output logic      [7:0]         o_reg_rdata,
  // analog comparator pins
  input  wire logic               i_power_on_reset_n,
  input  wire logic               i_rail_below_low,
  input  wire logic               i_rail_above_high,
  input  wire logic               i_buck_in_limit,
  input  wire logic               i_rail_below_bat,
  input  wire logic               i_charger_present,
  input  wire logic               i_rail_warn,
  input  wire logic               i_bkp_at_target,
  input  wire logic               i_bkp_cur_low,
  input  wire logic               i_bkp_below_resume,
  input  wire logic               i_rail_above_bkp,
  input  wire logic               i_rail_below_bkp_margin,
  input  wire logic               i_bat_above_bkp,
  // configuration from charger logic on this clock
  input  wire logic               i_charge_request,
  input  wire logic               i_fast_mode,
  input  wire logic [5:0]         i_ichg_set,
  input  wire logic [5:0]         i_thermal_ichg,
  input  wire logic [TIMER_W-1:0] i_timer_period,
  input  wire logic               i_timer_fixed,
  input  wire logic               i_ext_fet_cfg,
  input  wire logic [3:0]         i_usb_input_current_setting,
  input  wire logic [3:0]         i_bkp_cur_code,
  input  wire logic [4:0]         i_bkp_volt_code,
  input  wire logic               i_bkp_target_below_core,
  input  wire logic               i_auto_switch_dis,
  // outputs
  output logic [5:0]              o_ichg_eff,
  output logic                    o_charge_en,
  output logic                    o_timer_irq,
  output logic                    o_rail_warn_irq,
  output logic                    o_active_diode_en,
  output logic                    o_ext_fet_en,
  output logic [3:0]              o_buck_ilim_code,
  output logic                    o_buck_en,
  output logic                    o_buck_lp,
  output logic                    o_dline_sense_en,
  output logic [3:0]              o_bkp_cur_code,
  output logic [4:0]              o_bkp_volt_code,
  output logic                    o_bkp_charge_en,
  output logic                    o_vref_to_bkp,
  output logic                    o_vref_to_rail
);
  logic [csc_pkg::NUM_PINS-1:0] pins_s;
  logic                         por_s;
  logic                         low_s;
  logic                         high_s;
  logic                         lim_s;
  logic                         below_bat_s;
  logic                         chg_s;
  logic                         warn_s;
  logic                         at_tgt_s;
  logic                         cur_low_s;
  logic                         resume_s;
  logic                         above_bkp_s;
  logic                         below_bkp_s;
  logic                         bat_above_s;
  logic                         chg_d;
  logic                         warn_d;
  logic                         req_d;
  logic                         step_tick;
  logic                         timer_tick;
  logic [7:0]                   ctrl;
  logic [5:0]                   target;
  logic                         dec_cond;
  logic                         inc_cond;
  logic                         timer_run;
  logic                         expired;
  logic                         expire_pulse;
  logic [TIMER_W-1:0]           tcnt;
  logic [5:0]                   denom;
  logic [5:0]                   floor_rate;
  logic [5:0]                   rate;
  logic [6:0]                   acc;
  logic [6:0]                   acc_sum;
  logic                         bkp_suspended;
  logic                         inhibit;
  csc_pkg::csc_sw_state_t       sw_state;

  // every comparator pin is asynchronous to i_clk
  csc_sync #(
    .WIDTH (csc_pkg::NUM_PINS)
  ) u_sync (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_async  ({i_power_on_reset_n, i_rail_below_low, i_rail_above_high, i_buck_in_limit,
                i_rail_below_bat, i_charger_present, i_rail_warn, i_bkp_at_target,
                i_bkp_cur_low, i_bkp_below_resume, i_rail_above_bkp,
                i_rail_below_bkp_margin, i_bat_above_bkp}),
    .o_sync   (pins_s)
  );

  assign {por_s, low_s, high_s, lim_s, below_bat_s, chg_s, warn_s, at_tgt_s,
          cur_low_s, resume_s, above_bkp_s, below_bkp_s, bat_above_s} = pins_s;

  // charge current step interval
  csc_tick #(
    .CYCLES (CUR_STEP_CYCLES)
  ) u_step_tick (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_clear  (1'b0),
    .o_tick   (step_tick)
  );

  // safety timer base, restarted with each charge so periods are whole
  csc_tick #(
    .CYCLES (TIMER_TICK_CYCLES)
  ) u_timer_tick (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_clear  (i_charge_request && !req_d),
    .o_tick   (timer_tick)
  );

  // edge history for attach, warning and charge request
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      chg_d  <= 1'b0;
      warn_d <= 1'b0;
      req_d  <= 1'b0;
    end else begin
      chg_d  <= chg_s;
      warn_d <= warn_s;
      req_d  <= i_charge_request;
    end
  end

  // charger_buck_control; attach sets the enable over a host write
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      ctrl <= csc_pkg::BUCK_CTRL_RST;
    end else begin
      if (i_reg_wr && i_reg_addr == csc_pkg::BUCK_CTRL_ADDR) begin
        ctrl <= i_reg_wdata;
      end
      if (chg_s && !chg_d) begin
        ctrl[csc_pkg::BUCK_EN_BIT] <= 1'b1;
      end else if (!chg_s) begin
        ctrl[csc_pkg::BUCK_EN_BIT] <= 1'b0;
      end
      if (i_charge_request && !req_d) begin
        ctrl[csc_pkg::BUCK_LP_BIT] <= 1'b0; // low power cleared on charge start
      end
    end
  end

  // read data held until the next read; unmapped reads give zero
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      o_reg_rdata <= (i_reg_addr == csc_pkg::BUCK_CTRL_ADDR) ? ctrl : 8'h00;
    end
  end

  // buck limit selection; auto mode starts from the buck setting
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_buck_ilim_code <= 4'h0;
      o_buck_en        <= 1'b0;
      o_buck_lp        <= 1'b0;
      o_dline_sense_en <= 1'b0;
    end else begin
      o_buck_ilim_code <= ctrl[csc_pkg::USB_AUTO_BIT] ?
                          ctrl[csc_pkg::BUCK_ILIM_MSB:csc_pkg::BUCK_ILIM_LSB] :
                          i_usb_input_current_setting;
      o_dline_sense_en <= ctrl[csc_pkg::USB_AUTO_BIT];
      o_buck_en        <= ctrl[csc_pkg::BUCK_EN_BIT];
      o_buck_lp        <= ctrl[csc_pkg::BUCK_LP_BIT];
    end
  end

  // thermal cap only applies while thermal control is enabled
  always_comb begin
    target = i_ichg_set;
    if (ctrl[csc_pkg::THERM_EN_BIT] && i_thermal_ichg < i_ichg_set) begin
      target = i_thermal_ichg;
    end
    dec_cond = low_s && lim_s;
    inc_cond = high_s || !lim_s;
  end

  // charge current: one code per step so the current ramps rather than jumps
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_ichg_eff <= 6'h00;
    end else if (!o_charge_en) begin
      o_ichg_eff <= 6'h00;
    end else if (o_ichg_eff > target) begin
      o_ichg_eff <= target; // a lower setting applies at once
    end else if (step_tick) begin
      if (dec_cond && o_ichg_eff != 6'h00) begin
        o_ichg_eff <= o_ichg_eff - 6'h01;
      end else if (!dec_cond && inc_cond && o_ichg_eff < target) begin
        o_ichg_eff <= o_ichg_eff + 6'h01;
      end
    end
  end

  // active diode follows rail below battery, external fet optional
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_active_diode_en <= 1'b0;
      o_ext_fet_en      <= 1'b0;
    end else begin
      o_active_diode_en <= below_bat_s;
      o_ext_fet_en      <= below_bat_s && i_ext_fet_cfg;
    end
  end

  // timer rate: full rate unless fast charge is cut below half, floor is an eighth of the setting (at least 1)
  always_comb begin
    denom      = (i_ichg_set == 6'h00) ? 6'h01 : i_ichg_set;
    floor_rate = (denom[5:3] == 3'h0) ? 6'h01 : {3'h0, denom[5:3]};
    rate       = denom;
    if (i_fast_mode && !i_timer_fixed && {o_ichg_eff, 1'b0} < {1'b0, denom}) begin
      rate = (o_ichg_eff > floor_rate) ? o_ichg_eff : floor_rate;
    end
    acc_sum = acc + {1'b0, rate};
  end

  // safety timer, loaded on the rising charge request
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      timer_run    <= 1'b0;
      expired      <= 1'b0;
      expire_pulse <= 1'b0;
      tcnt         <= '0;
      acc          <= 7'h00;
    end else begin
      expire_pulse <= 1'b0;
      if (!i_charge_request) begin
        timer_run <= 1'b0;
        expired   <= 1'b0; // charging may start again on a new request
      end else if (!req_d) begin
        timer_run <= 1'b1;
        tcnt      <= i_timer_period;
        acc       <= 7'h00;
      end else if (timer_run && timer_tick) begin
        if (acc_sum >= {1'b0, denom}) begin
          acc <= acc_sum - {1'b0, denom};
          if (tcnt <= TIMER_W'(1)) begin
            tcnt         <= '0;
            timer_run    <= 1'b0;
            expired      <= 1'b1;
            expire_pulse <= 1'b1;
          end else begin
            tcnt <= tcnt - TIMER_W'(1);
          end
        end else begin
          acc <= acc_sum; // reduced current: the period stretches
        end
      end
    end
  end

  assign o_timer_irq = expire_pulse;
  assign o_charge_en = i_charge_request && !expired;

  // warning pulse on the rail supervision crossing, ahead of switch-over
  assign o_rail_warn_irq = warn_s && !warn_d;

  // backup charger settings and hysteresis
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_bkp_cur_code  <= 4'h0;
      o_bkp_volt_code <= 5'h00;
      bkp_suspended   <= 1'b0;
    end else begin
      o_bkp_cur_code  <= i_bkp_cur_code;
      o_bkp_volt_code <= (i_bkp_volt_code > csc_pkg::BKP_VOLT_MAX_CODE) ?
                         csc_pkg::BKP_VOLT_MAX_CODE : i_bkp_volt_code;
      if (resume_s) begin
        bkp_suspended <= 1'b0;
      end else if (at_tgt_s && cur_low_s) begin
        bkp_suspended <= 1'b1;
      end
    end
  end

  assign o_bkp_charge_en = por_s && !bkp_suspended;

  // battery switch; unpowered leaves the cell isolated
  assign inhibit = i_auto_switch_dis || i_bkp_target_below_core;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      sw_state <= csc_pkg::SW_OPEN;
    end else if (!por_s) begin
      sw_state <= csc_pkg::SW_OPEN;
    end else begin
      case (sw_state)
        csc_pkg::SW_OPEN: begin
          if (below_bkp_s && !inhibit) begin
            sw_state <= csc_pkg::SW_BACKUP;
          end else begin
            sw_state <= csc_pkg::SW_RAIL;
          end
        end
        csc_pkg::SW_RAIL: begin
          if (below_bkp_s && !inhibit) begin
            sw_state <= csc_pkg::SW_BACKUP;
          end
        end
        csc_pkg::SW_BACKUP: begin
          if (bat_above_s || (above_bkp_s && chg_s) || inhibit) begin
            sw_state <= csc_pkg::SW_RAIL;
          end
        end
        default: sw_state <= csc_pkg::SW_OPEN;
      endcase
    end
  end

  assign o_vref_to_bkp  = (sw_state == csc_pkg::SW_BACKUP);
  assign o_vref_to_rail = (sw_state == csc_pkg::SW_RAIL);

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  a_cur_reduce: assert property (step_tick && o_charge_en && dec_cond && o_ichg_eff != 6'h00
    && o_ichg_eff <= target ##1 o_charge_en |-> o_ichg_eff == $past(o_ichg_eff) - 6'h01)
    else $error("charge current not lowered under low rail and limit");
  a_cur_raise: assert property (step_tick && o_charge_en && !dec_cond && inc_cond
    && o_ichg_eff < target ##1 o_charge_en && o_ichg_eff <= target |-> o_ichg_eff == $past(o_ichg_eff) + 6'h01)
    else $error("charge current not raised toward setting");
  a_diode_follow: assert property (below_bat_s |=> o_active_diode_en)
    else $error("active diode not enabled with rail below battery");
  a_timer_load: assert property ($rose(i_charge_request) ##1 i_charge_request
    |-> timer_run && tcnt == $past(i_timer_period))
    else $error("safety timer not loaded on charge start");
  a_timer_stretch: assert property (i_fast_mode && !i_timer_fixed
    && denom > 6'h01 && {o_ichg_eff, 1'b0} < {1'b0, denom} |-> rate < denom)
    else $error("timer not stretched for reduced current");
  a_timer_bounds: assert property (i_timer_fixed |-> rate == denom)
    else $error("fixed timer rate differs from full rate");
  a_timer_cap: assert property ({3'h0, rate} >= {3'h0, denom} >> 3 && rate != 6'h00)
    else $error("timer extension exceeds eight times");
  a_expire_stop: assert property (o_timer_irq && i_charge_request |=> !o_charge_en
    && !timer_run && !o_timer_irq)
    else $error("charging not stopped after timer expiry");
  a_bkp_suspend: assert property (at_tgt_s && cur_low_s && !resume_s && por_s |=> !o_bkp_charge_en)
    else $error("backup charging not suspended");
  a_unpowered_off: assert property (!por_s |-> !o_bkp_charge_en ##1 !o_vref_to_bkp)
    else $error("backup cell used while unpowered");
  a_switch_inhibit: assert property (sw_state != csc_pkg::SW_BACKUP && inhibit
    |=> sw_state != csc_pkg::SW_BACKUP)
    else $error("backup connected while inhibited");
  a_buck_reattach: assert property (!chg_s |=> !ctrl[csc_pkg::BUCK_EN_BIT])
    else $error("buck enable kept without charger");

  c_expire: cover property (o_timer_irq);
  c_to_backup: cover property (sw_state == csc_pkg::SW_RAIL ##1 sw_state == csc_pkg::SW_BACKUP);
  c_cur_zero: cover property (o_charge_en && o_ichg_eff == 6'h00 && i_ichg_set != 6'h00);
endmodule : csc_top

// >>> tb/csc_partner.sv
// far-side model: main battery, backup cell and charger buck comparators
`timescale 1ns/1ns
module csc_partner #(
  parameter logic [15:0] WARN_MV = 16'hce4
) (
  input  wire logic [15:0] i_rail_mv,
  input  wire logic [15:0] i_bat_mv,
  input  wire logic [15:0] i_bkp_mv,
  input  wire logic        i_overload,
  input  wire logic [4:0]  i_bkp_volt_code,
  output logic             o_rail_below_low,
  output logic             o_rail_above_high,
  output logic             o_buck_in_limit,
  output logic             o_rail_below_bat,
  output logic             o_rail_warn,
  output logic             o_bkp_at_target,
  output logic             o_bkp_cur_low,
  output logic             o_bkp_below_resume,
  output logic             o_rail_above_bkp,
  output logic             o_rail_below_bkp_margin,
  output logic             o_bat_above_bkp
);
  logic [15:0] target_mv;
  // target follows the code the device applies, not the requested one
  assign target_mv = 16'h44c + 16'h64 * {11'h0, i_bkp_volt_code};
  // rail comparators against fixed thresholds, the warning level and the battery
  assign o_rail_below_low  = i_rail_mv <= 16'he10;
  assign o_rail_above_high = i_rail_mv > 16'hea6;
  assign o_rail_below_bat  = i_rail_mv < i_bat_mv;
  assign o_rail_warn       = i_rail_mv < WARN_MV;
  // buck sits in current limit only while the load overdraws it
  assign o_buck_in_limit = i_overload;
  // coin cell current tapers once it reaches the target
  assign o_bkp_at_target         = i_bkp_mv >= target_mv;
  assign o_bkp_cur_low           = i_bkp_mv >= target_mv;
  assign o_bkp_below_resume      = (i_bkp_mv + 16'hc8) < target_mv;
  assign o_rail_above_bkp        = i_rail_mv > i_bkp_mv;
  assign o_rail_below_bkp_margin = (i_rail_mv + 16'hc8) < i_bkp_mv;
  assign o_bat_above_bkp         = i_bat_mv > i_bkp_mv;
endmodule : csc_partner

// >>> tb/csc_top_test.sv
// self-checking bench for the charger supervisor control block
`timescale 1ns/1ns
module csc_top_test;
  localparam int DLY = 5;
  logic        i_clk, i_resetn, i_reg_wr, i_reg_rd, o_charge_en, o_timer_irq, o_rail_warn_irq;
  logic [7:0]  i_reg_addr, i_reg_wdata, o_reg_rdata, i_timer_period;
  logic        i_power_on_reset_n, i_rail_below_low, i_rail_above_high, i_buck_in_limit;
  logic        i_rail_below_bat, i_charger_present, i_rail_warn, i_bkp_at_target, i_bkp_cur_low;
  logic        i_bkp_below_resume, i_rail_above_bkp, i_rail_below_bkp_margin, i_bat_above_bkp;
  logic        i_charge_request, i_fast_mode, i_timer_fixed, i_ext_fet_cfg;
  logic        i_bkp_target_below_core, i_auto_switch_dis, o_active_diode_en, o_ext_fet_en;
  logic [5:0]  i_ichg_set, i_thermal_ichg, o_ichg_eff;
  logic [3:0]  i_usb_input_current_setting, i_bkp_cur_code, o_buck_ilim_code, o_bkp_cur_code;
  logic [4:0]  i_bkp_volt_code, o_bkp_volt_code;
  logic        o_buck_en, o_buck_lp, o_dline_sense_en, o_bkp_charge_en, o_vref_to_bkp, o_vref_to_rail;
  logic [15:0] rail_mv, bat_mv, bkp_mv;
  logic        overload;
  int          bad_count, compares, warn_seen, n, jumps;
  logic [5:0]  prev;

  csc_top #(.CUR_STEP_CYCLES(4), .TIMER_TICK_CYCLES(8), .TIMER_W(8)) DUT (
    .i_clk, .i_resetn, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
    .i_power_on_reset_n, .i_rail_below_low, .i_rail_above_high, .i_buck_in_limit, .i_rail_below_bat,
    .i_charger_present, .i_rail_warn, .i_bkp_at_target, .i_bkp_cur_low, .i_bkp_below_resume,
    .i_rail_above_bkp, .i_rail_below_bkp_margin, .i_bat_above_bkp, .i_charge_request, .i_fast_mode,
    .i_ichg_set, .i_thermal_ichg, .i_timer_period, .i_timer_fixed, .i_ext_fet_cfg,
    .i_usb_input_current_setting, .i_bkp_cur_code, .i_bkp_volt_code, .i_bkp_target_below_core,
    .i_auto_switch_dis, .o_ichg_eff, .o_charge_en, .o_timer_irq, .o_rail_warn_irq, .o_active_diode_en,
    .o_ext_fet_en, .o_buck_ilim_code, .o_buck_en, .o_buck_lp, .o_dline_sense_en, .o_bkp_cur_code,
    .o_bkp_volt_code, .o_bkp_charge_en, .o_vref_to_bkp, .o_vref_to_rail);

  csc_partner PARTNER (
    .i_rail_mv(rail_mv), .i_bat_mv(bat_mv), .i_bkp_mv(bkp_mv), .i_overload(overload),
    .i_bkp_volt_code(o_bkp_volt_code), .o_rail_below_low(i_rail_below_low),
    .o_rail_above_high(i_rail_above_high), .o_buck_in_limit(i_buck_in_limit),
    .o_rail_below_bat(i_rail_below_bat), .o_rail_warn(i_rail_warn), .o_bkp_at_target(i_bkp_at_target),
    .o_bkp_cur_low(i_bkp_cur_low), .o_bkp_below_resume(i_bkp_below_resume),
    .o_rail_above_bkp(i_rail_above_bkp), .o_rail_below_bkp_margin(i_rail_below_bkp_margin),
    .o_bat_above_bkp(i_bat_above_bkp));

  // 10 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  // warning pulses are counted mid-cycle, clear of the edge that launches them
  always @(negedge i_clk) begin
    if (o_rail_warn_irq === 1'b1) warn_seen++;
  end

  task automatic close_out;
    $display("compares=%0d mismatches=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // inputs always move DLY after a rising edge
  task automatic step(input int cnt);
    repeat (cnt) @(posedge i_clk);
    #DLY;
  endtask : step

  task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
    i_reg_addr  = addr;
    i_reg_wdata = data;
    i_reg_wr    = 1'b1;
    step(1);
    i_reg_wr = 1'b0;
    step(1);
  endtask : reg_write

  // read data lands on the edge that samples the strobe
  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    i_reg_addr = addr;
    i_reg_rd   = 1'b1;
    step(1);
    i_reg_rd = 1'b0;
    check(o_reg_rdata, exp, "register read");
    step(1);
  endtask : rd_chk

  task automatic sw(input logic [15:0] r, input logic [15:0] b, input logic exp_bkp);
    rail_mv = r;
    bat_mv  = b;
    step(5);
    check(o_vref_to_bkp, exp_bkp, "switch to backup");
    check(o_vref_to_rail, !exp_bkp, "switch to rail");
  endtask : sw

  // measures cycles from charge start to expiry
  task automatic run_timer(input logic fast, input logic fixed, output int cnt);
    i_charge_request = 1'b0;
    step(2);
    i_fast_mode      = fast;
    i_timer_fixed    = fixed;
    i_charge_request = 1'b1;
    cnt = 0;
    while (o_timer_irq !== 1'b1 && cnt < 200) begin
      step(1);
      cnt++;
    end
    step(1);
    check(o_timer_irq, 1'b0, "irq one cycle");
    check(o_charge_en, 1'b0, "charging stopped");
  endtask : run_timer

  // watchdog: whole run is a few hundred cycles
  initial begin
    repeat (20000) @(posedge i_clk);
    bad_count++;
    close_out();
  end

  initial begin
    {bad_count, compares, warn_seen} = '0;
    {i_resetn, i_reg_wr, i_reg_rd, i_power_on_reset_n, i_charger_present, overload} = '0;
    {i_charge_request, i_fast_mode, i_timer_fixed, i_bkp_target_below_core, i_auto_switch_dis} = '0;
    {i_reg_addr, i_reg_wdata} = '0;
    i_ext_fet_cfg = 1'b1;
    i_timer_period = 8'hff;
    i_ichg_set = 6'h0a;
    i_thermal_ichg = 6'h3f;
    i_usb_input_current_setting = 4'h9;
    i_bkp_cur_code = 4'hf;
    i_bkp_volt_code = 5'h19;
    {rail_mv, bat_mv} = '0;
    bkp_mv = 16'hbb8;
    step(5);
    i_resetn = 1'b1;
    step(4);
    check(o_vref_to_bkp, 1'b0, "unpowered cell held off");
    check(o_bkp_charge_en, 1'b0, "unpowered backup charger");
    rd_chk(8'h3e, 8'h80);
    rd_chk(8'h10, 8'h00);
    // enable bit cannot be set by the host while no charger
    reg_write(8'h3e, 8'h90);
    rd_chk(8'h3e, 8'h80);
    i_charger_present = 1'b1;
    step(5);
    rd_chk(8'h3e, 8'h90);
    check(o_buck_en, 1'b1, "buck enable");
    reg_write(8'h3e, 8'h80);
    step(8);
    rd_chk(8'h3e, 8'h80);
    i_charger_present = 1'b0;
    step(5);
    i_charger_present = 1'b1;
    step(5);
    rd_chk(8'h3e, 8'h90);
    reg_write(8'h3e, 8'h85);
    step(2);
    check(o_buck_ilim_code, 4'h9, "usb limit used");
    check(o_dline_sense_en, 1'b0, "no line sensing");
    reg_write(8'h3e, 8'he5);
    step(2);
    check(o_buck_ilim_code, 4'h5, "buck limit used");
    check(o_buck_lp, 1'b1, "low power set");
    check(o_dline_sense_en, 1'b1, "line sensing");
    // power up: rail above backup takes the reference
    i_power_on_reset_n = 1'b1;
    sw(16'hed8, 16'he74, 1'b0);
    check(o_bkp_cur_code, 4'hf, "backup current code");
    check(o_bkp_volt_code, 5'h14, "backup voltage clamp");
    i_bkp_volt_code = 5'h13;
    bkp_mv = 16'h9c4;
    step(5);
    check(o_bkp_charge_en, 1'b1, "backup charging");
    bkp_mv = 16'hbb8;
    step(5);
    check(o_bkp_charge_en, 1'b0, "backup suspended");
    bkp_mv = 16'hb54;
    step(5);
    check(o_bkp_charge_en, 1'b0, "inside hysteresis");
    bkp_mv = 16'ha8c;
    step(5);
    check(o_bkp_charge_en, 1'b1, "backup resumed");
    bkp_mv = 16'hbb8;
    // charge current ramps up to the setting
    i_fast_mode = 1'b1;
    i_timer_fixed = 1'b1;
    i_charge_request = 1'b1;
    step(60);
    check(o_ichg_eff, 6'h0a, "ramp to setting");
    check(o_active_diode_en, 1'b0, "diode idle");
    rd_chk(8'h3e, 8'hc5);
    check(o_buck_lp, 1'b0, "low power cleared on charge start");
    rail_mv = 16'hdac;
    overload = 1'b1;
    prev = o_ichg_eff;
    jumps = 0;
    for (int i = 0; i < 60; i++) begin
      step(1);
      if (o_ichg_eff > prev || prev - o_ichg_eff > 6'h01) jumps++;
      prev = o_ichg_eff;
    end
    check(8'(jumps), 8'h00, "single code steps");
    check(o_ichg_eff, 6'h00, "throttled to zero");
    check(o_active_diode_en, 1'b1, "diode on");
    check(o_ext_fet_en, 1'b1, "external fet on");
    // between thresholds: limit decides
    rail_mv = 16'he74;
    overload = 1'b0;
    n = 0;
    while (o_ichg_eff < 6'h04 && n < 100) begin
      step(1);
      n++;
    end
    check(8'(n < 100), 8'h01, "raise without limit");
    overload = 1'b1;
    step(3);
    prev = o_ichg_eff;
    step(20);
    check(o_ichg_eff, prev, "hold between thresholds");
    rail_mv = 16'hed8;
    step(60);
    check(o_ichg_eff, 6'h0a, "raise above high");
    i_thermal_ichg = 6'h06;
    step(3);
    check(o_ichg_eff, 6'h06, "thermal cap");
    i_thermal_ichg = 6'h3f;
    // safety timer: keep the current at zero to force extension
    rail_mv = 16'hdac;
    i_ichg_set = 6'h10;
    i_timer_period = 8'h01;
    step(20);
    run_timer(1'b1, 1'b1, n);
    check(8'(n >= 6 && n <= 12), 8'h01, "fixed timer");
    run_timer(1'b1, 1'b0, n);
    check(8'(n >= 60 && n <= 72), 8'h01, "extended timer");
    run_timer(1'b0, 1'b0, n);
    check(8'(n >= 6 && n <= 12), 8'h01, "pre-charge timer");
    // battery switch with charger removed
    i_charger_present = 1'b0;
    sw(16'hed8, 16'he74, 1'b0);
    n = warn_seen;
    sw(16'ha8c, 16'ha8c, 1'b1);
    check(8'(warn_seen - n), 8'h01, "one warning");
    sw(16'hb86, 16'hb86, 1'b1);
    sw(16'hbea, 16'hc1c, 1'b0);
    i_auto_switch_dis = 1'b1;
    sw(16'ha8c, 16'ha8c, 1'b0);
    i_auto_switch_dis = 1'b0;
    i_bkp_target_below_core = 1'b1;
    sw(16'ha8c, 16'ha8c, 1'b0);
    i_bkp_target_below_core = 1'b0;
    sw(16'ha8c, 16'ha8c, 1'b1);
    i_power_on_reset_n = 1'b0;
    step(5);
    check(o_vref_to_bkp, 1'b0, "unpowered cell released");
    check(o_bkp_charge_en, 1'b0, "unpowered charger off");
    close_out();
  end
endmodule : csc_top_test
